// *** hdl/stop_bar_sequence_controller.v ***
/*
  Stop bar sequence controller: panel button sequencing with two
  backup timers and two vehicle sensors, sensor override, failure
  modes by visibility, combined red/yellow guard fixtures, lamp
  monitoring and a classic Wishbone register slave.
  Assumes all inputs are synchronous to clk; panel and sensor
  inputs are level contacts; comm_alive pulses while the link works.
*/
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stop_bar_map.vh"

module stop_bar_sequence_controller #(
  parameter N_LAMPS = 8,
  parameter integer CLK_HZ = `CLK_HZ,
  parameter integer TICK_DIV = `CLK_HZ / `TICK_HZ,
  parameter integer COMM_TIMEOUT_TICKS = `COMM_TIMEOUT_SEC * `TICK_HZ
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // Classic Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Tower panel and field inputs
  input wire bar_button,
  input wire override_button,
  input wire sensor1,
  input wire sensor2,
  input wire comm_alive,
  input wire unit_fail,
  input wire local_low_vis,
  input wire local_mode_sel,
  input wire [N_LAMPS-1:0] lamp_ok,
  // Lamp drivers and panel indication
  output reg red_on,
  output reg seg1_on,
  output reg seg2_on,
  output reg [N_LAMPS-1:0] red_lamp_en,
  output reg yellow_even_on,
  output reg yellow_odd_on,
  output reg [1:0] intensity_out,
  output reg bar_failed_ind
);

  // ----------------------------------------------------------------
  // Derived timing counts (in ticks)
  // ----------------------------------------------------------------
  localparam integer T1_TICKS = `T1_SEC * `TICK_HZ;
  localparam integer T2_TICKS = `T2_SEC * `TICK_HZ;
  localparam integer FAILOFF_TICKS = `FAILOFF_SEC * `TICK_HZ;
  // Half a flash period in ticks: 60 s / flashes / 2
  localparam integer HALF_FLASH_TICKS = (60 * `TICK_HZ) / (`FLASH_PER_MIN * 2);
  localparam integer CW = $clog2(N_LAMPS + 1);

  // S_IDLE : red bar lit (at low visibility), lead-on dark
  // S_BOTH : red dark, both lead-on segments lit, timers running
  // S_SEG2 : red relit, only segment two lit until sensor two
  // S_OVR : as S_BOTH but blind to sensors and timer one until timer two ends
  // Codes are plain binary; the default branch recovers to idle.
  // Sequencer states
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_BOTH = 2'd1;
  localparam [1:0] S_SEG2 = 2'd2;
  localparam [1:0] S_OVR = 2'd3;

  // Used for the status count; a lamp that reads 0 is dead.
  // Kept as a function so the width follows N_LAMPS.
  // Count of zero bits in a lamp vector
  function [CW-1:0] count_fail;
    input [N_LAMPS-1:0] v;
    integer i;
    begin
      count_fail = {CW{1'b0}};
      for (i = 0; i < N_LAMPS; i = i + 1)
        if (!v[i])
          count_fail = count_fail + 1'b1;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [4:0] ctrl_ff;
  reg [1:0] inten_ff;
  reg [23:0] div_ff;
  reg tick_ff;
  reg [3:0] btn_ff, ovr_ff, s1_ff, s2_ff, com_ff;
  reg [1:0] state_ff;
  reg [15:0] t1_ff, t2_ff;
  reg [15:0] comm_cnt_ff;
  reg comm_fail_ff;
  reg [15:0] failoff_ff;
  reg failoff_done_ff;
  reg [7:0] flash_ff;
  reg phase_ff;
  reg failed_latch_ff;
  reg [N_LAMPS-1:0] lamp_ok_ff;

  // A held contact gives one event only: the edge is taken between
  // the last two stages, so a long press cannot restart a sequence.
  // Edge detection after the two-flop synchroniser stage
  wire btn_rise = btn_ff[2] & ~btn_ff[3];
  wire s1_rise = s1_ff[2] & ~s1_ff[3];
  wire s2_rise = s2_ff[2] & ~s2_ff[3];
  wire com_rise = com_ff[2] & ~com_ff[3];
  wire ovr_lvl = ovr_ff[2];

  wire sys_on = ctrl_ff[`CTRL_SYS_ON];
  wire master_off = ctrl_ff[`CTRL_MASTER_OFF];
  // Local selection is honoured only after the link is lost
  wire low_vis = (comm_fail_ff & local_mode_sel) ? local_low_vis : ctrl_ff[`CTRL_LOW_VIS];
  wire [CW-1:0] nfail = count_fail(lamp_ok_ff);
  wire adjacent = |(~lamp_ok_ff[N_LAMPS-1:1] & ~lamp_ok_ff[N_LAMPS-2:0]);
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // ----------------------------------------------------------------
  // Input synchronisers and timebase
  // ----------------------------------------------------------------
  // Bits 1..0 synchronise, 2..3 feed the edge detector
  always @(posedge clk) begin
    if (rst) begin
      btn_ff <= 4'h0;
      ovr_ff <= 4'h0;
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      com_ff <= 4'h0;
      div_ff <= 24'h000000;
      tick_ff <= 1'b0;
      lamp_ok_ff <= {N_LAMPS{1'b1}};
    end else if (ce) begin
      btn_ff <= {btn_ff[2:0], bar_button};
      ovr_ff <= {ovr_ff[2:0], override_button};
      s1_ff <= {s1_ff[2:0], sensor1};
      s2_ff <= {s2_ff[2:0], sensor2};
      com_ff <= {com_ff[2:0], comm_alive};
      lamp_ok_ff <= lamp_ok;
      // Fixed-rate tick drives every timer
      if (div_ff == TICK_DIV - 1) begin
        div_ff <= 24'h000000;
        tick_ff <= 1'b1;
      end else begin
        div_ff <= div_ff + 24'h000001;
        tick_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stop bar sequencer
  // ----------------------------------------------------------------
  // Lamps switch two clocks after the detected press edge, far
  // inside the two second limit.
  // Timers count down on ticks in every state; a stale count left
  // in idle is harmless because a press reloads both.
  // Sensor two is tested first in S_BOTH so an early detection
  // ends the whole sequence rather than stepping to S_SEG2.
  always @(posedge clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      t1_ff <= 16'h0000;
      t2_ff <= 16'h0000;
    end else if (ce) begin
      if (tick_ff && t1_ff != 16'h0000)
        t1_ff <= t1_ff - 16'h0001;
      if (tick_ff && t2_ff != 16'h0000)
        t2_ff <= t2_ff - 16'h0001;
      case (state_ff)
        S_IDLE: begin
          if (btn_rise && sys_on) begin
            t1_ff <= T1_TICKS[15:0];
            t2_ff <= T2_TICKS[15:0];
            state_ff <= ovr_lvl ? S_OVR : S_BOTH;
          end
        end
        S_BOTH: begin
          if (s2_rise || (tick_ff && t2_ff == 16'h0001))
            state_ff <= S_IDLE;
          else if (s1_rise || (tick_ff && t1_ff == 16'h0001))
            state_ff <= S_SEG2;
        end
        S_SEG2: begin
          if (s2_rise || (tick_ff && t2_ff == 16'h0001))
            state_ff <= S_IDLE;
        end
        S_OVR: begin
          // Sensors are not looked at here
          if (tick_ff && t2_ff == 16'h0001)
            state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Communication watchdog, fail-off timer, failure latch
  // ----------------------------------------------------------------
  // The link is judged dead after a run of ticks with no heartbeat
  // edge; a stuck-high heartbeat counts as dead as well.
  // The fail-off timer only runs while enabled by software, so a bar
  // held on at low visibility is not switched off unasked.
  always @(posedge clk) begin
    if (rst) begin
      comm_cnt_ff <= 16'h0000;
      comm_fail_ff <= 1'b0;
      failoff_ff <= 16'h0000;
      failoff_done_ff <= 1'b0;
      failed_latch_ff <= 1'b0;
    end else if (ce) begin
      if (com_rise) begin
        comm_cnt_ff <= 16'h0000;
        comm_fail_ff <= 1'b0;
      end else if (tick_ff && !comm_fail_ff) begin
        if (comm_cnt_ff == COMM_TIMEOUT_TICKS - 1)
          comm_fail_ff <= 1'b1;
        else
          comm_cnt_ff <= comm_cnt_ff + 16'h0001;
      end
      // Fail-off timer counts from failure or from enable, whichever comes later
      if (!comm_fail_ff || !ctrl_ff[`CTRL_FAILSAFE_TIMER]) begin
        failoff_ff <= 16'h0000;
        failoff_done_ff <= 1'b0;
      end else if (tick_ff && !failoff_done_ff) begin
        if (failoff_ff == FAILOFF_TICKS - 1)
          failoff_done_ff <= 1'b1;
        else
          failoff_ff <= failoff_ff + 16'h0001;
      end
      // Set wins over the return-to-service clear
      if (comm_fail_ff || unit_fail)
        failed_latch_ff <= 1'b1;
      else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_CTRL && wb_dat_i[`CTRL_RETURN_SVC])
        failed_latch_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Guard light flasher
  // ----------------------------------------------------------------
  // Integer rounding of the half period makes the rate depend on
  // the tick; check the flash count whenever TICK_HZ changes.
  always @(posedge clk) begin
    if (rst) begin
      flash_ff <= 8'h00;
      phase_ff <= 1'b0;
    end else if (ce && tick_ff) begin
      // Keeps running through comm failure so yellow pulses on
      if (flash_ff == HALF_FLASH_TICKS - 1) begin
        flash_ff <= 8'h00;
        phase_ff <= ~phase_ff;
      end else begin
        flash_ff <= flash_ff + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lamp outputs
  // ----------------------------------------------------------------
  // Priority, lowest first: sequence, link failure, then the global
  // off conditions, which override everything.
  reg nxt_red, nxt_seg1, nxt_seg2, nxt_yel;
  always @* begin
    nxt_red = (state_ff != S_BOTH) && (state_ff != S_OVR);
    nxt_seg1 = (state_ff == S_BOTH) || (state_ff == S_OVR);
    nxt_seg2 = state_ff != S_IDLE;
    nxt_yel = 1'b0;
    if (comm_fail_ff) begin
      nxt_red = low_vis;
      nxt_seg1 = 1'b0;
      nxt_seg2 = 1'b0;
      nxt_yel = ~low_vis;
      if (failoff_done_ff) begin
        nxt_red = 1'b0;
        nxt_yel = 1'b0;
      end
    end else begin
      // Yellow only at high visibility and never with lead-on lit
      nxt_yel = ~low_vis & ~nxt_seg1 & ~nxt_seg2;
      nxt_red = nxt_red & low_vis;
    end
    if (!sys_on || master_off || unit_fail) begin
      nxt_red = 1'b0;
      nxt_seg1 = 1'b0;
      nxt_seg2 = 1'b0;
      nxt_yel = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      red_on <= 1'b0;
      seg1_on <= 1'b0;
      seg2_on <= 1'b0;
      red_lamp_en <= {N_LAMPS{1'b0}};
      yellow_even_on <= 1'b0;
      yellow_odd_on <= 1'b0;
      intensity_out <= `INTENSITY_RESET;
      bar_failed_ind <= 1'b0;
    end else if (ce) begin
      red_on <= nxt_red;
      seg1_on <= nxt_seg1;
      seg2_on <= nxt_seg2;
      // Per-lamp enables: a dead lamp drops out alone
      red_lamp_en <= {N_LAMPS{nxt_red}} & lamp_ok_ff;
      yellow_even_on <= nxt_yel & ~phase_ff;
      yellow_odd_on <= nxt_yel & phase_ff;
      intensity_out <= inten_ff;
      bar_failed_ind <= failed_latch_ff;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone register slave: ack one cycle after request
  // ----------------------------------------------------------------
  // ack is refused while high so a held request is taken every other cycle; any
  // unmapped offset reads zero and ignores writes.
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_ff <= `CTRL_RESET;
      inten_ff <= `INTENSITY_RESET;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          `REG_CTRL: ctrl_ff <= {1'b0, wb_dat_i[3:0]};
          `REG_INTENSITY: inten_ff <= wb_dat_i[1:0];
          default: ;
        endcase
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= {27'h0000000, ctrl_ff};
          `REG_STATUS: wb_dat_o <= {{(24-CW){1'b0}}, nfail, 1'b0, adjacent, failed_latch_ff,
                                    comm_fail_ff, state_ff == S_OVR, seg2_on, seg1_on, red_on};
          `REG_INTENSITY: wb_dat_o <= {30'h00000000, inten_ff};
          `REG_LAMP_FAIL: wb_dat_o <= {{(32-N_LAMPS){1'b0}}, ~lamp_ok_ff};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // stop_bar_sequence_controller
`default_nettype wire

// *** hdl/stop_bar_map.vh ***
/*
  Constants for the stop bar sequence controller: register offsets,
  field positions, reset values and timing figures.
  Assumes a 25 MHz system clock and a 32-bit classic Wishbone bus.
*/
`ifndef STOP_BAR_MAP_VH
`define STOP_BAR_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_INTENSITY 4'h8
`define REG_LAMP_FAIL 4'hC

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_SYS_ON 0
`define CTRL_MASTER_OFF 1
`define CTRL_LOW_VIS 2
`define CTRL_FAILSAFE_TIMER 3
`define CTRL_RETURN_SVC 4
`define CTRL_RESET 5'h00

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ST_RED 0
`define ST_SEG1 1
`define ST_SEG2 2
`define ST_OVERRIDE 3
`define ST_COMM_FAIL 4
`define ST_BAR_FAILED 5
`define ST_ADJACENT 6
`define ST_COUNT_LSB 8

// ----------------------------------------------------------------
// Timing figures and reset values
// ----------------------------------------------------------------
`define CLK_HZ 25000000
`define TICK_HZ 10
`define T1_SEC 45
`define T2_SEC 120
`define FAILOFF_SEC 600
`define FLASH_PER_MIN 31
`define COMM_TIMEOUT_SEC 2
`define INTENSITY_RESET 2'h1

`endif

// *** tb/sbc_chk.sv ***
/* Port checker for the stop bar controller.
   Assumes one clock, sync reset; bound into the top design module. */
`timescale 1ns/1ps
`default_nettype none
module sbc_chk #(parameter N_LAMPS = 8) (
  // Clock, bus
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Field and lamps
  input wire logic bar_button,
  input wire logic unit_fail,
  input wire logic [N_LAMPS-1:0] lamp_ok,
  input wire logic red_on,
  input wire logic seg1_on,
  input wire logic seg2_on,
  input wire logic [N_LAMPS-1:0] red_lamp_en,
  input wire logic yellow_even_on,
  input wire logic yellow_odd_on,
  input wire logic [1:0] intensity_out,
  input wire logic bar_failed_ind
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // -----------------------------------------
  // Sequencing steps
  // -----------------------------------------
  sequence s_press;
    $rose(bar_button) && red_on && !seg1_on && !seg2_on;
  endsequence
  sequence s_proceed;
    !red_on && seg1_on && seg2_on;
  endsequence
  a_press_proceed: assert property (s_press |-> ##[1:8] s_proceed)
    else $error("press did not reach proceed");
  a_proceed_no_yel: assert property (seg1_on || seg2_on |-> !yellow_even_on && !yellow_odd_on)
    else $error("yellow lit while lead-on lit");
  a_yel_alternate: assert property (!(yellow_even_on && yellow_odd_on))
    else $error("both guard sets lit");
  a_unit_off: assert property (unit_fail [*6] |-> !red_on && !seg1_on && !seg2_on && !yellow_even_on)
    else $error("lamps lit with failed unit");
  a_lamp_enable: assert property (red_lamp_en == ($past(lamp_ok, 2) & {N_LAMPS{red_on}}))
    else $error("lamp enable not red and healthy");
  a_intens_write: assert property ($changed(intensity_out) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 4'h8))
    else $error("intensity moved without a write");
  a_latch_hold: assert property ($fell(bar_failed_ind) |-> $past(wb_ack_o && wb_we_i && wb_dat_i[4]))
    else $error("failed latch cleared by itself");
  a_ack_answer: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // sbc_chk
`default_nettype wire

// *** tb/field_model.sv ***
/* Field side: link heartbeat and two vehicle sensors.
   Assumes the bench asks for a detection with a one-cycle go pulse. */
`timescale 1ns/1ps
`default_nettype none
module field_model (
  // Clock and bench requests
  input wire logic clk,
  input wire logic hb_en,
  input wire logic [1:0] go,
  // Field outputs
  output logic comm_alive,
  output logic sensor1,
  output logic sensor2
);
  logic [1:0] hb_ff = 2'h0;
  logic [3:0] s1_ff = 4'h0;
  logic [3:0] s2_ff = 4'h0;
  // Heartbeat stands low when the link is down; a detection lasts 8 cycles
  always_ff @(posedge clk) begin
    hb_ff <= hb_en ? hb_ff + 2'h1 : 2'h0;
    s1_ff <= go[0] ? 4'h8 : s1_ff - {3'h0, s1_ff != 4'h0};
    s2_ff <= go[1] ? 4'h8 : s2_ff - {3'h0, s2_ff != 4'h0};
  end
  assign comm_alive = hb_ff[1];
  assign sensor1 = s1_ff != 4'h0;
  assign sensor2 = s2_ff != 4'h0;
endmodule // field_model
`default_nettype wire

// *** tb/tb.sv ***
/* Self-checking bench for the stop bar controller.
   Assumes a shortened tick (4 clocks) and link timeout (4 ticks). */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TD = 4;
  localparam int T1 = 450 * TD;
  localparam int T2 = 1200 * TD;
  localparam int TF = 6000 * TD;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic bar_button = 1'b0, override_button = 1'b0, unit_fail = 1'b0, local_low_vis = 1'b0;
  logic local_mode_sel = 1'b0, hb_en = 1'b1, sensor1, sensor2, comm_alive;
  logic [7:0] lamp_ok = 8'hFB, red_lamp_en;
  logic [1:0] go = 2'h0, intensity_out;
  logic red_on, seg1_on, seg2_on, yellow_even_on, yellow_odd_on, bar_failed_ind;
  int errors = 0, total_checks = 0;
  // Register rows: address, write value, value read back
  logic [3:0] ra [6] = '{4'h8, 4'h8, 4'hC, 4'h2, 4'h0, 4'h0};
  logic [31:0] rw [6] = '{32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1F, 32'h5};
  logic [31:0] re [6] = '{32'h3, 32'h0, 32'h4, 32'h0, 32'hF, 32'h5};

  stop_bar_sequence_controller #(.TICK_DIV(TD), .COMM_TIMEOUT_TICKS(4)) dut (.clk, .rst, .ce, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bar_button, .override_button,
    .sensor1, .sensor2, .comm_alive, .unit_fail, .local_low_vis, .local_mode_sel, .lamp_ok, .red_on, .seg1_on,
    .seg2_on, .red_lamp_en, .yellow_even_on, .yellow_odd_on, .intensity_out, .bar_failed_ind);
  field_model fm (.clk, .hb_en, .go, .comm_alive, .sensor1, .sensor2);

  // Free-running 25 MHz clock
  initial forever #20 clk = ~clk;

  // -----------------------------------------
  // Tasks
  // -----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Classic cycle; waits for ack, bounded so a dead slave cannot hang us
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    // Data taken at the edge where ack is sampled, then released
    q = wb_dat_o;
    chk("ack", 32'h1, {31'h0, n < 20});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // Wait up to lim cycles for red, seg1, seg2 to reach e
  task automatic lamps(input string n, input logic [2:0] e, input int lim);
    int k;
    k = 0;
    @(negedge clk);
    while ({red_on, seg1_on, seg2_on} !== e && k < lim) begin
      k++;
      @(negedge clk);
    end
    chk(n, {29'h0, e}, {29'h0, red_on, seg1_on, seg2_on});
  endtask
  task automatic yel();
    logic b;
    int k;
    k = 0;
    @(negedge clk);
    b = yellow_even_on;
    while (yellow_even_on === b && k < 100) begin
      k++;
      @(negedge clk);
    end
    chk("yellow toggles", 32'h1, {31'h0, yellow_even_on !== b});
  endtask
  task automatic press();
    @(posedge clk);
    bar_button <= 1'b1;
    repeat (4) @(posedge clk);
    bar_button <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    go <= 2'(1 << i);
    @(posedge clk);
    go <= 2'h0;
  endtask
  task automatic finish_test();
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // -----------------------------------------
  // Main sequence
  // -----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    lamps("reset lamps", 3'b000, 0);
    chk("reset intensity", 32'h1, {30'h0, intensity_out});
    bus(4'h0, 1'b0, 32'h0);
    chk("reset ctrl", 32'h0, q);
    for (int i = 0; i < 6; i++) begin
      bus(ra[i], 1'b1, rw[i]);
      bus(ra[i], 1'b0, 32'h0);
      chk("reg row", re[i], q);
    end
    chk("intensity out", 32'h0, {30'h0, intensity_out});
    lamps("idle", 3'b100, 20);
    press();
    lamps("proceed", 3'b011, 20);
    bus(4'h4, 1'b0, 32'h0);
    chk("status", 32'h106, q & 32'hFF07);
    pulse(0);
    lamps("sensor one", 3'b101, 30);
    pulse(1);
    lamps("sensor two", 3'b100, 30);
    @(posedge clk);
    lamp_ok <= 8'hE7;
    repeat (10) @(posedge clk);
    bus(4'h4, 1'b0, 32'h0);
    chk("adjacent", 32'h240, q & 32'hFF40);
    chk("lamp enables", 32'hE7, {24'h0, red_lamp_en});
    press();
    lamps("proceed", 3'b011, 20);
    pulse(1);
    lamps("early two", 3'b100, 30);
    // Backup timers alone, checked just before and after each expiry
    press();
    lamps("proceed", 3'b011, 20);
    repeat (T1 - 40) @(posedge clk);
    lamps("t1 hold", 3'b011, 0);
    lamps("t1 end", 3'b101, 80);
    repeat (T2 - T1 - 120) @(posedge clk);
    lamps("t2 hold", 3'b101, 0);
    lamps("t2 end", 3'b100, 200);
    @(posedge clk);
    override_button <= 1'b1;
    press();
    override_button <= 1'b0;
    lamps("override", 3'b011, 20);
    pulse(0);
    pulse(1);
    repeat (40) @(posedge clk);
    lamps("sensors ignored", 3'b011, 0);
    repeat (T2 - 200) @(posedge clk);
    lamps("override hold", 3'b011, 0);
    lamps("override end", 3'b100, 300);
    bus(4'h0, 1'b1, 32'h7);
    lamps("master off", 3'b000, 20);
    bus(4'h0, 1'b1, 32'h5);
    lamps("master on", 3'b100, 20);
    bus(4'h0, 1'b1, 32'h1);
    lamps("high vis", 3'b000, 20);
    yel();
    // Link loss: high visibility first, then the bar fails on at low
    @(posedge clk);
    hb_en <= 1'b0;
    repeat (40) @(posedge clk);
    lamps("comm high", 3'b000, 0);
    yel();
    bus(4'h0, 1'b1, 32'hD);
    lamps("comm low", 3'b100, 20);
    chk("yellow off", 32'h0, {31'h0, yellow_even_on | yellow_odd_on});
    @(posedge clk);
    local_mode_sel <= 1'b1;
    lamps("local mode", 3'b000, 20);
    @(posedge clk);
    local_mode_sel <= 1'b0;
    lamps("remote mode", 3'b100, 20);
    repeat (TF - 400) @(posedge clk);
    lamps("failsafe hold", 3'b100, 0);
    lamps("failsafe", 3'b000, 600);
    chk("latched", 32'h1, {31'h0, bar_failed_ind});
    @(posedge clk);
    hb_en <= 1'b1;
    repeat (40) @(posedge clk);
    bus(4'h0, 1'b1, 32'h10);
    @(negedge clk);
    chk("return", 32'h0, {31'h0, bar_failed_ind});
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(4'h0, 1'b1, 32'h5);
    lamps("after reset", 3'b100, 20);
    @(posedge clk);
    unit_fail <= 1'b1;
    lamps("unit fail", 3'b000, 20);
    finish_test();
  end

  // Whole run needs about 34000 cycles; this leaves wide margin
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule // tb

bind stop_bar_sequence_controller sbc_chk #(.N_LAMPS(N_LAMPS)) u_chk (.clk, .rst, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .bar_button, .unit_fail, .lamp_ok, .red_on, .seg1_on, .seg2_on,
  .red_lamp_en, .yellow_even_on, .yellow_odd_on, .intensity_out, .bar_failed_ind);
`default_nettype wire
